// File: hdl/rmpu_pkg.sv
// package: register map, field layout and attribute encodings
package rmpu_pkg;
   localparam int          NUM_REGIONS = 8;
   localparam logic [31:0] OFF_TYPE    = 32'he000_ed90;
   localparam logic [31:0] OFF_CTRL    = 32'he000_ed94;
   localparam logic [31:0] OFF_RSEL    = 32'he000_ed98;
   localparam logic [31:0] OFF_RBASE   = 32'he000_ed9c;
   localparam logic [31:0] OFF_RLIMIT  = 32'he000_eda0;
   localparam logic [31:0] OFF_RBASE_A = 32'he000_eda4;
   localparam logic [31:0] OFF_RLIM_A  = 32'he000_eda8;
   localparam logic [31:0] OFF_ATTR_LO = 32'he000_edc0;
   localparam logic [31:0] OFF_ATTR_HI = 32'he000_edc4;
   localparam logic [31:0] OFF_SFSTAT  = 32'he000_ede4;
   localparam logic [31:0] OFF_SFADDR  = 32'he000_ede8;
   localparam logic [7:0]  REGION_CNT  = 8'h08;
   localparam logic [31:0] TYPE_VALUE  = {16'h0000, REGION_CNT, 8'h00};
   localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
   localparam int          CTRL_ENABLE = 0;
   localparam int          CTRL_HFNMI  = 1;
   localparam int          CTRL_PRIVDF = 2;
   localparam int          SFSTAT_VALID = 6;
   localparam int          LIM_EN      = 0;
   localparam int          BASE_XN     = 0;
   localparam int          BASE_AP_LO  = 1;
   localparam int          BASE_SH_LO  = 3;
   localparam int          LIM_IDX_LO  = 1;
   localparam logic [3:0]  ALIAS_STEP  = 4'h8;
   // attribute byte: upper nibble 0 selects device memory
   localparam logic [7:0]  ATTR_STRICT  = 8'h00;
   localparam logic [7:0]  ATTR_EARLY   = 8'h04;
   localparam logic [7:0]  ATTR_REORDER = 8'h08;
   localparam logic [7:0]  ATTR_GATHER  = 8'h0c;
   localparam logic [1:0]  SH_OUTER     = 2'h2;
   localparam logic [1:0]  SH_INNER     = 2'h3;
   typedef enum logic [2:0] {
      rmpu_strict, rmpu_early, rmpu_reorder, rmpu_gather,
      rmpu_normal_nc, rmpu_normal_wt, rmpu_normal_wb
   } rmpu_mtype_e;
endpackage

// File: hdl/rmpu_regs_if.sv
// interface: region table write port and read/lookup ports
`timescale 1ns/10ps
`default_nettype none
interface rmpu_regs_if;
   logic        wr_base;
   logic        wr_limit;
   logic [2:0]  wr_idx;
   logic [31:0] wr_data;
   logic [2:0]  rd_idx;
   logic [31:0] rd_base;
   logic [31:0] rd_limit;
   logic [31:0] base_all  [8];
   logic [31:0] limit_all [8];
   modport owner (input wr_base, wr_limit, wr_idx, wr_data, rd_idx,
                  output rd_base, rd_limit, base_all, limit_all);
   modport user  (output wr_base, wr_limit, wr_idx, wr_data, rd_idx,
                  input rd_base, rd_limit, base_all, limit_all);
endinterface
`default_nettype wire

// File: hdl/rmpu_region_mem.sv
// module: storage of the eight region base/limit words
`timescale 1ns/10ps
`default_nettype none
module rmpu_region_mem
(
   input  wire logic   pclk,
   input  wire logic   presetn,
   input  wire logic   pclken,
   rmpu_regs_if.owner  rif
);
   typedef struct packed {
      logic [7:0][31:0] base;
      logic [7:0][31:0] limit;
      logic [31:0]      rd_base;
      logic [31:0]      rd_limit;
   } rmpu_mem_s;
   rmpu_mem_s st_ff;
   rmpu_mem_s nxt_st;

   always_comb
   begin
      nxt_st = st_ff;
      if (rif.wr_base)
         nxt_st.base[rif.wr_idx] = rif.wr_data;
      if (rif.wr_limit)
         nxt_st.limit[rif.wr_idx] = rif.wr_data;
      nxt_st.rd_base  = nxt_st.base[rif.rd_idx];
      nxt_st.rd_limit = nxt_st.limit[rif.rd_idx];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_ff <= '0;
      else if (pclken)
         st_ff <= nxt_st;
   end

   assign rif.rd_base  = st_ff.rd_base;
   assign rif.rd_limit = st_ff.rd_limit;
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_out
         assign rif.base_all[g]  = st_ff.base[g];
         assign rif.limit_all[g] = st_ff.limit[g];
      end
   endgenerate
endmodule
`default_nettype wire

// File: hdl/rmpu_top.sv
// module: region protection unit with apb registers and access check
// How it works
// R1: when valid, fault address holds the address of a security violation; a secure write to the fault address still replaces it while valid stays set.
// R2: eight regions, each with base, limit, permissions and attributes.
// R3: one secure and one non-secure unit instance possible; one instance here.
// R4: an access hitting two or more regions faults.
// R5: fetches and data accesses use the same region table.
// R6: a prohibited access raises a memory-management fault.
// R7: each region selects its own attribute byte.
// R8: matched region attributes are exported with each access.
// R9: strict device memory is ordered and always reported shared.
// R10: device types order strict, early-ack, reorderable, gathering.
// R11: normal: shareable or not; non-cacheable, write-through or write-back.
// R12: three alias base/limit pairs address regions select+1 to +3.
// R13: read-only type register reports presence and region count.
// R14: type register banked per security state; both copies identical.
// R15: region count field bits 15:8 reads 0x08.
// R16: bit 0 always reads zero, meaning unified regions.
// R17: type register value is a fixed constant.
// R18: all regions checked combinationally in the request cycle.
// R19: valid flag bit 6 of fault status set when address captured.
// R20: non-secure access to fault address reads zero, writes ignored.
`timescale 1ns/10ps
`default_nettype none
module rmpu_top
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        pclken,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   input  wire logic        pprot_ns,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        acc_valid,
   input  wire logic [31:0] acc_addr,
   input  wire logic        acc_write,
   input  wire logic        acc_fetch,
   input  wire logic        acc_priv,
   input  wire logic        acc_hfnmi,
   output logic             acc_allow,
   output logic             memory_management_fault,
   output logic [2:0]       acc_mtype,
   output logic             acc_shared,
   output logic             acc_ordered,
   output logic             acc_region_hit,
   output logic [2:0]       acc_region,
   input  wire logic        sau_violation,
   input  wire logic [31:0] sau_addr,
   output logic             secure_fault_address_valid
);
   typedef struct packed {
      logic [31:0] ctrl;
      logic [7:0]  rsel;
      logic [31:0] attr_lo;
      logic [31:0] attr_hi;
      logic [31:0] sfaddr;
      logic        sfvalid;
      logic [31:0] rdata;
      logic        slverr;
   } rmpu_state_s;
   rmpu_state_s st_ff;
   rmpu_state_s nxt_st;

   rmpu_regs_if rif ();

   // one region table: a single unit instance [R3]
   rmpu_region_mem u_mem
   (
      .pclk    (pclk),
      .presetn (presetn),
      .pclken  (pclken),
      .rif     (rif)
   );

   // alias registers: offset selects region select plus 0..3
   function automatic logic [1:0] alias_of(input logic [31:0] a);
      logic [4:0] d;
      d = 5'(a - rmpu_pkg::OFF_RBASE);
      alias_of = 2'(d / {1'b0, rmpu_pkg::ALIAS_STEP});
   endfunction

   function automatic logic is_pair(input logic [31:0] a, input logic lim);
      logic [31:0] d;
      d = a - rmpu_pkg::OFF_RBASE;
      is_pair = (a >= rmpu_pkg::OFF_RBASE) && (d < 32'h0000_0020)
                && (d[2] == lim) && (d[1:0] == 2'h0);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  s);
      for (int b = 0; b < 4; b++)
         merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
   endfunction

   // register decode shared by the read and write setup paths
   function automatic logic is_mapped(input logic [31:0] a);
      unique case (a)
         rmpu_pkg::OFF_TYPE,
         rmpu_pkg::OFF_CTRL,
         rmpu_pkg::OFF_RSEL,
         rmpu_pkg::OFF_ATTR_LO,
         rmpu_pkg::OFF_ATTR_HI,
         rmpu_pkg::OFF_SFADDR,
         rmpu_pkg::OFF_SFSTAT:
            is_mapped = 1'b1;
         default:
            is_mapped = is_pair(a, 1'b0) || is_pair(a, 1'b1);
      endcase
   endfunction

   logic        wr_acc;
   logic        rd_acc;
   logic [2:0]  pair_idx;
   logic [7:0]  hits;
   logic [3:0]  hit_cnt;
   logic [2:0]  hit_idx;
   logic [7:0]  attr_byte;
   logic        en_chk;
   logic        perm_bad;

   assign wr_acc   = psel && penable && pwrite && pclken;
   assign rd_acc   = psel && !penable && !pwrite;
   assign pready   = 1'b1;
   assign pair_idx = 3'(st_ff.rsel[2:0] + {1'b0, alias_of(paddr)}); // [R12]

   assign rif.wr_idx   = pair_idx;
   assign rif.wr_data  = pwdata;
   assign rif.wr_base  = wr_acc && is_pair(paddr, 1'b0);
   assign rif.wr_limit = wr_acc && is_pair(paddr, 1'b1);
   assign rif.rd_idx   = pair_idx;

   // region match over all eight regions in the request cycle
   genvar g;
   generate
      for (g = 0; g < rmpu_pkg::NUM_REGIONS; g++)
      begin : g_hit
         assign hits[g] = rif.limit_all[g][rmpu_pkg::LIM_EN]
            && (acc_addr[31:5] >= rif.base_all[g][31:5])
            && (acc_addr[31:5] <= rif.limit_all[g][31:5]); // [R2] [R5] [R18]
      end
   endgenerate

   always_comb
   begin
      hit_cnt = '0;
      hit_idx = '0;
      for (int i = rmpu_pkg::NUM_REGIONS - 1; i >= 0; i--)
      begin
         hit_cnt = hit_cnt + {3'h0, hits[i]};
         if (hits[i])
            hit_idx = 3'(i);
      end
   end

   // per-region attribute index picks a byte of the indirection pair
   always_comb
   begin
      logic [2:0]  ai;
      logic [63:0] both;
      ai   = rif.limit_all[hit_idx][rmpu_pkg::LIM_IDX_LO +: 3];
      both = {st_ff.attr_hi, st_ff.attr_lo};
      attr_byte = both[ai*8 +: 8]; // [R7]
   end

   always_comb
   begin
      logic [31:0] b;
      logic [1:0]  ap;
      b  = rif.base_all[hit_idx];
      ap = b[rmpu_pkg::BASE_AP_LO +: 2];
      perm_bad = (acc_fetch && b[rmpu_pkg::BASE_XN])
               || (acc_write && ap[1])
               || (!acc_priv && !ap[0]);
   end

   assign en_chk = st_ff.ctrl[rmpu_pkg::CTRL_ENABLE]
                   && (!acc_hfnmi || st_ff.ctrl[rmpu_pkg::CTRL_HFNMI]);

   always_comb
   begin
      logic bad;
      bad = 1'b0;
      if (en_chk)
      begin
         if (hit_cnt > 4'h1)
            bad = 1'b1; // [R4]
         else if (hit_cnt == 4'h0)
            bad = !(acc_priv && st_ff.ctrl[rmpu_pkg::CTRL_PRIVDF]);
         else
            bad = perm_bad;
      end
      memory_management_fault = acc_valid && bad; // [R6]
      acc_allow               = acc_valid && !bad;
      acc_region_hit          = en_chk && (hit_cnt == 4'h1);
      acc_region              = hit_idx;
   end

   // attribute export to the system
   always_comb
   begin
      logic [1:0] sh;
      sh = rif.base_all[hit_idx][rmpu_pkg::BASE_SH_LO +: 2];
      acc_ordered = 1'b0;
      acc_shared  = 1'b1;
      if (!acc_region_hit)
         acc_mtype = rmpu_pkg::rmpu_normal_nc;
      else if (attr_byte[7:4] == 4'h0)
      begin
         unique case (attr_byte[3:2]) // [R10]
            2'h0:
            begin
               acc_mtype   = rmpu_pkg::rmpu_strict;
               acc_ordered = 1'b1; // [R9]
            end
            2'h1: acc_mtype = rmpu_pkg::rmpu_early;
            2'h2: acc_mtype = rmpu_pkg::rmpu_reorder;
            2'h3: acc_mtype = rmpu_pkg::rmpu_gather;
         endcase
      end
      else
      begin
         acc_shared = (sh == rmpu_pkg::SH_OUTER) || (sh == rmpu_pkg::SH_INNER);
         if (attr_byte[7:6] == 2'h1)
            acc_mtype = rmpu_pkg::rmpu_normal_nc; // [R11]
         else if (attr_byte[6] == 1'b0)
            acc_mtype = rmpu_pkg::rmpu_normal_wt;
         else
            acc_mtype = rmpu_pkg::rmpu_normal_wb;
      end
   end // [R8]

   always_comb
   begin
      nxt_st = st_ff;
      if (sau_violation)
      begin
         nxt_st.sfaddr  = sau_addr; // [R1]
         nxt_st.sfvalid = 1'b1; // [R19]
      end
      if (wr_acc)
      begin
         unique case (paddr)
            rmpu_pkg::OFF_CTRL:
               nxt_st.ctrl = merge(st_ff.ctrl, pwdata, pstrb)
                             & 32'h0000_0007;
            rmpu_pkg::OFF_RSEL:
               nxt_st.rsel = {5'h0, pwdata[2:0]};
            rmpu_pkg::OFF_ATTR_LO:
               nxt_st.attr_lo = merge(st_ff.attr_lo, pwdata, pstrb);
            rmpu_pkg::OFF_ATTR_HI:
               nxt_st.attr_hi = merge(st_ff.attr_hi, pwdata, pstrb);
            rmpu_pkg::OFF_SFADDR:
               if (!pprot_ns && !sau_violation)
                  nxt_st.sfaddr = pwdata; // [R20]
            rmpu_pkg::OFF_SFSTAT:
               if (!pprot_ns && pwdata[rmpu_pkg::SFSTAT_VALID]
                   && !sau_violation)
                  nxt_st.sfvalid = 1'b0;
            default: ;
         endcase
      end
      if (rd_acc)
      begin
         nxt_st.slverr = 1'b0;
         unique case (paddr)
            rmpu_pkg::OFF_TYPE:    nxt_st.rdata = rmpu_pkg::TYPE_VALUE;
            // [R13] [R14] [R15] [R16] [R17]
            rmpu_pkg::OFF_CTRL:    nxt_st.rdata = st_ff.ctrl;
            rmpu_pkg::OFF_RSEL:    nxt_st.rdata = {24'h0, st_ff.rsel};
            rmpu_pkg::OFF_ATTR_LO: nxt_st.rdata = st_ff.attr_lo;
            rmpu_pkg::OFF_ATTR_HI: nxt_st.rdata = st_ff.attr_hi;
            rmpu_pkg::OFF_SFADDR:
               nxt_st.rdata = pprot_ns ? 32'h0000_0000 : st_ff.sfaddr;
            rmpu_pkg::OFF_SFSTAT:
               nxt_st.rdata = pprot_ns ? 32'h0000_0000
                  : 32'(st_ff.sfvalid) << rmpu_pkg::SFSTAT_VALID;
            default:
            begin
               nxt_st.rdata  = 32'h0000_0000;
               nxt_st.slverr = !is_mapped(paddr);
            end
         endcase
      end
      else if (psel && !penable && pwrite)
         nxt_st.slverr = !is_mapped(paddr);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff      <= '0;
         st_ff.ctrl <= rmpu_pkg::CTRL_RESET;
      end
      else if (pclken)
         st_ff <= nxt_st;
   end

   // pair registers come from the memory's read register
   always_comb
   begin
      prdata = st_ff.rdata;
      if (is_pair(paddr, 1'b0))
         prdata = rif.rd_base;
      else if (is_pair(paddr, 1'b1))
         prdata = rif.rd_limit;
   end
   assign pslverr = psel && penable && st_ff.slverr;
   assign secure_fault_address_valid = st_ff.sfvalid;
endmodule
`default_nettype wire

// File: verification/rmpu_checker_assertions.sv
// checker: concurrent properties on the protection unit ports
`timescale 1ns/10ps
`default_nettype none
module rmpu_checker
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        pclken,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pprot_ns,
   input wire logic [31:0] prdata,
   input wire logic        acc_valid,
   input wire logic        acc_allow,
   input wire logic        memory_management_fault,
   input wire logic [2:0]  acc_mtype,
   input wire logic        acc_shared,
   input wire logic        acc_ordered,
   input wire logic        acc_region_hit,
   input wire logic        sau_violation,
   input wire logic        secure_fault_address_valid
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_acc;
   logic st_wr;
   assign rd_acc = psel && penable && !pwrite;
   assign st_wr  = psel && penable && pwrite
                   && (paddr == rmpu_pkg::OFF_SFSTAT);
   a_fault_blocks_allow: assert property (
      acc_valid && memory_management_fault |-> !acc_allow)
      else $error("fault with access allowed");
   a_strict_shared: assert property (
      acc_valid && acc_allow && acc_region_hit && acc_mtype == 3'h0
      |-> acc_shared && acc_ordered) else $error("strict not shared");
   a_mtype_range: assert property (
      acc_valid && acc_region_hit
      |-> acc_mtype <= 3'h6 && acc_ordered == (acc_mtype == 3'h0))
      else $error("memory type or ordering wrong");
   a_valid_set: assert property (
      pclken && sau_violation |=> secure_fault_address_valid)
      else $error("valid flag not set");
   a_valid_hold: assert property (
      secure_fault_address_valid && !st_wr |=> secure_fault_address_valid)
      else $error("valid flag lost");
   a_valid_clear: assert property (
      st_wr && pclken && !pprot_ns && pwdata[6] && !sau_violation
      |=> !secure_fault_address_valid) else $error("valid not cleared");
   a_type_const: assert property (
      rd_acc && paddr == rmpu_pkg::OFF_TYPE
      |-> prdata == rmpu_pkg::TYPE_VALUE) else $error("type value wrong");
   a_ns_raz: assert property (
      rd_acc && pprot_ns && paddr == rmpu_pkg::OFF_SFADDR
      |-> prdata == 32'h0000_0000) else $error("fault address not zero");
   c_fault: cover property (acc_valid && memory_management_fault);
   c_sau: cover property (sau_violation);
   c_wb: cover property (acc_valid && acc_region_hit && acc_mtype == 3'h6);
endmodule
bind rmpu_top rmpu_checker u_rmpu_checker (.pclk, .presetn, .pclken,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pprot_ns, .prdata,
   .acc_valid, .acc_allow, .memory_management_fault, .acc_mtype,
   .acc_shared, .acc_ordered, .acc_region_hit, .sau_violation,
   .secure_fault_address_valid);
`default_nettype wire

// File: verification/rmpu_core_model.sv
// model: core access path issuing fetches and data accesses
`timescale 1ns/10ps
`default_nettype none
module rmpu_core_model
(
   input  wire logic    pclk,
   output var logic        acc_valid,
   output var logic [31:0] acc_addr,
   output var logic        acc_write,
   output var logic        acc_fetch,
   output var logic        acc_priv
);
   initial
   begin
      acc_valid = 1'b0;
      acc_addr  = 32'h0000_0000;
      acc_write = 1'b0;
      acc_fetch = 1'b0;
      acc_priv  = 1'b0;
   end
   // fetches and data share one request path
   task go(input logic [31:0] a, input logic w, f, p);
      @(posedge pclk);
      acc_valid <= 1'b1;
      acc_addr  <= a;
      acc_write <= w;
      acc_fetch <= f;
      acc_priv  <= p;
   endtask
   // released lines show the inverse of their last value
   task stop;
      @(posedge pclk);
      acc_valid <= 1'b0;
      acc_addr  <= ~acc_addr;
      acc_write <= ~acc_write;
      acc_fetch <= ~acc_fetch;
      acc_priv  <= ~acc_priv;
   endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// testbench: register access, region lookup and secure fault capture
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pprot_ns, pready;
   logic        pslverr, acc_valid, acc_write, acc_fetch, acc_priv;
   logic        acc_allow, memory_management_fault, acc_shared;
   logic        acc_ordered, acc_region_hit, sau_violation, sfav, hfnmi;
   logic [2:0]  acc_mtype, acc_region;
   logic [31:0] paddr, pwdata, prdata, acc_addr, sau_addr;
   int          n_errors, num_checks, cyc;
   rmpu_top u_rmpu_top (.pclk, .presetn, .pclken(1'b1), .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb(4'hf), .pprot_ns, .pready, .prdata,
      .pslverr, .acc_valid, .acc_addr, .acc_write, .acc_fetch, .acc_priv,
      .acc_hfnmi(hfnmi), .acc_allow, .memory_management_fault, .acc_mtype,
      .acc_shared, .acc_ordered, .acc_region_hit, .acc_region,
      .sau_violation, .sau_addr, .secure_fault_address_valid(sfav));
   rmpu_core_model u_rmpu_core_model (.pclk, .acc_valid, .acc_addr,
      .acc_write, .acc_fetch, .acc_priv);
   task give_verdict;
      if (n_errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, s);
      num_checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task apb(input logic w, input logic [31:0] a, d,
            output logic [31:0] q, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [31:0] a, d);
      logic [31:0] q;
      logic        er;
      apb(1'b1, a, d, q, er);
   endtask
   task rd(input logic [31:0] a, e);
      logic [31:0] q;
      logic        er;
      apb(1'b0, a, 32'h0000_0000, q, er);
      chk("prdata", e, q);
   endtask
   task reg_set(input int r, input logic [31:0] b, l);
      wr(rmpu_pkg::OFF_RSEL, 32'(r));
      wr(rmpu_pkg::OFF_RBASE, b);
      wr(rmpu_pkg::OFF_RLIMIT, l);
   endtask
   task acc(input logic [31:0] a, input logic w, f, p, al,
            input logic [2:0] r, input logic sh);
      u_rmpu_core_model.go(a, w, f, p);
      #1;
      chk("acc_allow", 32'(al), 32'(acc_allow));
      chk("fault", 32'(!al), 32'(memory_management_fault));
      if (al)
      begin
         chk("hit", 32'h0000_0001, 32'(acc_region_hit));
         chk("region", 32'(r), 32'(acc_region));
         chk("mtype", 32'(r), 32'(acc_mtype));
         chk("shared", 32'(sh), 32'(acc_shared));
      end
      u_rmpu_core_model.stop();
   endtask
   task t_regs;
      logic [31:0] q;
      logic        er;
      rd(rmpu_pkg::OFF_TYPE, rmpu_pkg::TYPE_VALUE);
      rd(rmpu_pkg::OFF_CTRL, 32'h0000_0000);
      wr(rmpu_pkg::OFF_TYPE, 32'hffff_ffff);
      rd(rmpu_pkg::OFF_TYPE, rmpu_pkg::TYPE_VALUE);
      pprot_ns <= 1'b1;
      rd(rmpu_pkg::OFF_TYPE, rmpu_pkg::TYPE_VALUE);
      pprot_ns <= 1'b0;
      apb(1'b0, 32'he000_ed00, 32'h0000_0000, q, er);
      chk("pslverr", 32'h0000_0001, 32'(er));
      chk("unmapped", 32'h0000_0000, q);
   endtask
   task t_sfault;
      logic [31:0] q;
      logic        er;
      chk("sfav", 32'h0000_0000, 32'(sfav));
      @(posedge pclk);
      sau_violation <= 1'b1;
      sau_addr <= 32'h2000_0040;
      @(posedge pclk);
      sau_violation <= 1'b0;
      sau_addr <= 32'hdfff_ffbf;
      #1 chk("sfav", 32'h0000_0001, 32'(sfav));
      rd(rmpu_pkg::OFF_SFADDR, 32'h2000_0040);
      apb(1'b0, rmpu_pkg::OFF_SFSTAT, 32'h0000_0000, q, er);
      chk("status", 32'h0000_0040, q & 32'h0000_0040);
      pprot_ns <= 1'b1;
      rd(rmpu_pkg::OFF_SFADDR, 32'h0000_0000);
      wr(rmpu_pkg::OFF_SFADDR, 32'h0000_0000);
      wr(rmpu_pkg::OFF_SFSTAT, 32'h0000_0040);
      pprot_ns <= 1'b0;
      rd(rmpu_pkg::OFF_SFADDR, 32'h2000_0040);
      chk("sfav", 32'h0000_0001, 32'(sfav));
      wr(rmpu_pkg::OFF_SFSTAT, 32'h0000_0040);
      #1 chk("sfav", 32'h0000_0000, 32'(sfav));
   endtask
   task t_regions;
      wr(rmpu_pkg::OFF_ATTR_LO, 32'h0c08_0400);
      wr(rmpu_pkg::OFF_ATTR_HI, 32'h44ff_8844);
      for (int r = 0; r < 7; r++)
         reg_set(r, r * 32'h0000_1000 | (r == 5 ? 32'h2 : 32'h1a),
                 r * 32'h0000_1000 | 32'h0000_0fe1 | (r << 1));
      wr(rmpu_pkg::OFF_CTRL, 32'h0000_0001);
      for (int r = 0; r < 7; r++)
         acc(r * 32'h0000_1000 + 32'h10, 1'b0, r[0], 1'b1, 1'b1,
             r[2:0], r != 5);
      wr(rmpu_pkg::OFF_RSEL, 32'h0000_0006);
      wr(rmpu_pkg::OFF_RBASE_A, 32'h0000_0002);
      wr(rmpu_pkg::OFF_RLIM_A, 32'h0000_0fef);
      wr(rmpu_pkg::OFF_RSEL, 32'h0000_0005);
      rd(32'he000_edac, 32'h0000_0002);
      rd(32'he000_edb0, 32'h0000_0fef);
      rd(32'he000_edb4, 32'h0000_001a);
      acc(32'h0000_0010, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0);
   endtask
   task t_perms;
      reg_set(1, 32'h0000_101d, 32'h0000_1fe3);
      acc(32'h0000_1010, 1'b0, 1'b0, 1'b1, 1'b1, 3'h1, 1'b1);
      acc(32'h0000_1010, 1'b1, 1'b0, 1'b1, 1'b0, 3'h1, 1'b1);
      acc(32'h0000_1010, 1'b0, 1'b1, 1'b1, 1'b0, 3'h1, 1'b1);
      acc(32'h0000_1010, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1, 1'b1);
      acc(32'h9000_0000, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0);
      hfnmi <= 1'b1;
      u_rmpu_core_model.go(32'h9000_0000, 1'b0, 1'b0, 1'b0);
      #1 chk("hfnmi_off", 32'h0000_0001, 32'(acc_allow));
      wr(rmpu_pkg::OFF_CTRL, 32'h0000_0007);
      #1 chk("bg", 32'h0000_0001, 32'(memory_management_fault));
      u_rmpu_core_model.go(32'h9000_0000, 1'b0, 1'b0, 1'b1);
      #1 chk("bg_priv", 32'h0000_0001, 32'(acc_allow));
      u_rmpu_core_model.stop();
      hfnmi <= 1'b0;
   endtask
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_errors++;
         give_verdict;
      end
   end
   initial
   begin
      {presetn, psel, penable, pwrite, pprot_ns, sau_violation} = 6'h00;
      hfnmi = 1'b0;
      {paddr, pwdata, sau_addr} = {32'h0000_0000, 32'h0, 32'h0};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_sfault();
      t_regions();
      t_perms();
      give_verdict;
   end
endmodule
`default_nettype wire
